/* File: bench/agsc_top_bench.sv */
// self-checking bench for the gain soft-step control block
`include "agsc_defs.svh"

module agsc_top_bench
  import agsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic                 clk_sys;
  logic                 sys_rst;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [9:0]           paddr;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 sample_tick;
  logic [1:0][6:0]      agc_gain;
  agsc_chan_s [1:0]     chan_gain;
  logic [1:0]           chan_active;
  logic                 irq;
  agsc_chan_s           gl;
  agsc_chan_s           gr;
  int                   n_errors;
  int                   n_checks;

  assign gl = chan_gain[0];
  assign gr = chan_gain[1];

  agsc_top agsc_top_inst (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .sample_tick (sample_tick),
    .agc_gain    (agc_gain),
    .chan_gain   (chan_gain),
    .chan_active (chan_active),
    .irq         (irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; the bench never assumes the wait-state count
  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
           output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    logic        e;
    apb(1'b1, idx, wd, d, e);
  endtask

  task rdchk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    apb(1'b0, idx, 32'h0, d, e);
    chk(d, exp);
  endtask

  task settle();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  task tick();
    @(posedge clk_sys);
    sample_tick <= 1'b1;
    @(posedge clk_sys);
    sample_tick <= 1'b0;
  endtask

  task t_reset();
    logic [31:0] d;
    logic        e;
    rdchk(`AGSC_IDX_AMP_L, 32'h0);
    rdchk(`AGSC_IDX_AMP_R, 32'h0);
    rdchk(`AGSC_IDX_SOFTSTEP, 32'h0);
    rdchk(`AGSC_IDX_TRIM, 32'h0);
    rdchk(`AGSC_IDX_VOL_L, 32'h0);
    rdchk(`AGSC_IDX_VOL_R, 32'h0);
    chk(32'(gl.pga_mute), 32'h1);
    chk(32'(gr.pga_mute), 32'h1);
    // unmapped index must be refused with zero data
    apb(1'b0, 8'h10, 32'h0, d, e);
    chk({31'h0, e}, 32'h1);
    chk(d, 32'h0);
  endtask

  task t_amp();
    wr(`AGSC_IDX_SOFTSTEP, 32'h2);
    wr(`AGSC_IDX_CTRL, 32'h3);
    settle();
    chk(32'(gl.pga_mute), 32'h1);
    wr(`AGSC_IDX_AMP_L, 32'h5f);
    settle();
    chk(32'(gl.pga_mute), 32'h0);
    chk(32'(gl.pga_hdb), 32'h5f);
    wr(`AGSC_IDX_CTRL, 32'h7);
    settle();
    chk(32'(gl.pga_hdb), 32'h6b);
    wr(`AGSC_IDX_CTRL, 32'h27);
    settle();
    chk(32'(gl.pga_hdb), 32'h53);
    wr(`AGSC_IDX_CTRL, 32'h3);
    rdchk(`AGSC_IDX_AMP_L, 32'h5f);
    chk(32'(gr.pga_mute), 32'h1);
  endtask

  task t_vol();
    wr(`AGSC_IDX_VOL_L, 32'h68);
    wr(`AGSC_IDX_VOL_R, 32'h28);
    settle();
    chk(32'(gl.vol_hdb), -32'sh18);
    chk(32'(gr.vol_hdb), 32'h28);
    wr(`AGSC_IDX_VOL_L, 32'h7f);
    settle();
    chk(32'(gl.vol_hdb), -32'sh1);
    chk(32'(gr.vol_hdb), 32'h28);
    rdchk(`AGSC_IDX_VOL_L, 32'h7f);
  endtask

  task t_trim();
    wr(`AGSC_IDX_VOL_L, 32'h0);
    wr(`AGSC_IDX_TRIM, 32'h43);
    settle();
    chk(32'(gl.trim_tenth), 32'h4);
    chk(32'(gr.trim_tenth), 32'h3);
    chk(32'(gl.total_tenth), 32'h1d7);
    wr(`AGSC_IDX_TRIM, 32'h50);
    settle();
    chk(32'(gl.trim_tenth), 32'h0);
    chk(32'(gl.total_tenth), 32'h1db);
  endtask

  // fast then slow stepping, reached flags and the interrupt
  task t_step();
    logic [31:0] d;
    logic        e;
    wr(`AGSC_IDX_SOFTSTEP, 32'h0);
    wr(`AGSC_IDX_IRQ_STAT, 32'hf);
    wr(`AGSC_IDX_IRQ_MASK, 32'h1);
    wr(`AGSC_IDX_AMP_L, 32'h5c);
    wr(`AGSC_IDX_VOL_L, 32'h4);
    tick();
    settle();
    chk(32'(gl.pga_hdb), 32'h5e);
    chk(32'(gl.vol_hdb), 32'h1);
    chk(32'(irq), 32'h0);
    apb(1'b0, `AGSC_IDX_REACHED, 32'h0, d, e);
    chk(d & 32'he0, 32'h0);
    repeat (2) tick();
    settle();
    chk(32'(gl.pga_hdb), 32'h5c);
    chk(32'(gl.vol_hdb), 32'h3);
    chk(32'(irq), 32'h1);
    tick();
    settle();
    apb(1'b0, `AGSC_IDX_REACHED, 32'h0, d, e);
    chk(d & 32'he0, 32'he0);
    apb(1'b0, `AGSC_IDX_IRQ_STAT, 32'h0, d, e);
    chk(d & 32'h5, 32'h5);
    wr(`AGSC_IDX_IRQ_STAT, 32'h1);
    settle();
    chk(32'(irq), 32'h0);
    wr(`AGSC_IDX_SOFTSTEP, 32'h1);
    wr(`AGSC_IDX_VOL_L, 32'hc);
    tick();
    settle();
    chk(32'(gl.vol_hdb), 32'h6);
    // two slow ticks give exactly one amp step, whatever the phase
    wr(`AGSC_IDX_AMP_L, 32'h5a);
    repeat (2) tick();
    settle();
    chk(32'(gl.pga_hdb), 32'h5b);
  endtask

  task t_agc();
    wr(`AGSC_IDX_SOFTSTEP, 32'h2);
    agc_gain[0] <= 7'h10;
    wr(`AGSC_IDX_CTRL, 32'h103);
    settle();
    chk(32'(gl.pga_hdb), 32'h10);
    wr(`AGSC_IDX_CTRL, 32'h3);
    settle();
    chk(32'(gl.pga_hdb), 32'h5a);
  endtask

  task t_pdown();
    int n;
    wr(`AGSC_IDX_SOFTSTEP, 32'h0);
    wr(`AGSC_IDX_CTRL, 32'h0);
    tick();
    settle();
    chk(32'(chan_active[0]), 32'h1);
    chk(32'(gl.pga_hdb), 32'h59);
    n = 0;
    while (chan_active !== 2'b00 && n < 200) begin
      tick();
      n++;
    end
    if (chan_active !== 2'b00) begin
      n_errors++;
      summarize();
    end
    settle();
    chk(32'(gl.pga_mute), 32'h1);
    chk(32'(gl.vol_hdb), -32'sh18);
    chk(32'(gr.vol_hdb), -32'sh18);
    rdchk(`AGSC_IDX_PWR_STAT, 32'h0);
    // power back on: first fast step climbs out of mute
    wr(`AGSC_IDX_CTRL, 32'h1);
    tick();
    settle();
    chk(32'(gl.pga_hdb), 32'h0);
    chk(32'(chan_active), 32'h1);
  endtask

  initial begin
    n_errors    = 0;
    n_checks    = 0;
    sys_rst     = 1'b1;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 10'h0;
    pwdata      = 32'h0;
    sample_tick = 1'b0;
    agc_gain    = '0;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_amp();
    t_vol();
    t_trim();
    t_step();
    t_agc();
    t_pdown();
    summarize();
  end
endmodule

/* File: design/agsc_defs.svh */
// register indices, field positions, reset values and gain limits
`ifndef AGSC_DEFS_SVH
`define AGSC_DEFS_SVH

// register indices; the byte address is four times the index
`define AGSC_IDX_REACHED   8'h24
`define AGSC_IDX_AMP_L     8'h3b
`define AGSC_IDX_AMP_R     8'h3c
`define AGSC_IDX_SOFTSTEP  8'h51
`define AGSC_IDX_TRIM      8'h52
`define AGSC_IDX_VOL_L     8'h53
`define AGSC_IDX_VOL_R     8'h54
`define AGSC_IDX_CTRL      8'h60
`define AGSC_IDX_IRQ_STAT  8'h61
`define AGSC_IDX_IRQ_MASK  8'h62
`define AGSC_IDX_PWR_STAT  8'h63

// reached flags: both-reached, amp-reached, volume-reached
`define AGSC_BIT_REACH_L   7
`define AGSC_BIT_AMP_L     6
`define AGSC_BIT_VOL_L     5
`define AGSC_BIT_REACH_R   3
`define AGSC_BIT_AMP_R     2
`define AGSC_BIT_VOL_R     1

// control register fields
`define AGSC_CTRL_ON       0
`define AGSC_CTRL_DIFF     2
`define AGSC_CTRL_IMP_L    4
`define AGSC_CTRL_IMP_R    6
`define AGSC_CTRL_AGC      8

// trim field positions
`define AGSC_TRIM_L        4
`define AGSC_TRIM_R        0
`define AGSC_TRIM_MAX      3'h4

// reset values
`define AGSC_RST_AMP       7'h00
`define AGSC_RST_VOL       7'h00
`define AGSC_RST_STEP      2'h0
`define AGSC_RST_TRIM      8'h00
`define AGSC_RST_CTRL      9'h000

// gain limits and offsets in half-dB units, and the tenths-per-half-dB scale
`define AGSC_PGA_MUTE      8'hff
`define AGSC_PGA_MAX       8'h5f
`define AGSC_VOL_MIN       8'he8
`define AGSC_VOL_MAX       8'h28
`define AGSC_DIFF_BOOST    9'h00c
`define AGSC_IMP_STEP      9'h00c
`define AGSC_TENTHS_PER_HDB 11'h005

`endif

/* File: design/agsc_pkg.sv */
// types shared by the gain soft-step control block
package agsc_pkg;

  typedef enum logic [1:0] {
    AGSC_RATE_FAST,
    AGSC_RATE_SLOW,
    AGSC_RATE_OFF
  } agsc_rate_e;

  typedef struct packed {
    logic               pga_mute;
    logic signed [8:0]  pga_hdb;
    logic signed [6:0]  vol_hdb;
    logic        [2:0]  trim_tenth;
    logic signed [10:0] total_tenth;
  } agsc_chan_s;

endpackage

/* File: design/agsc_top.sv */
// record-path gain soft-step control with apb register slave
//
// Decided for this implementation: register access over APB.
`include "agsc_defs.svh"

module agsc_top
  import agsc_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   sys_rst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic       [9:0]       paddr,
  input  wire logic       [31:0]      pwdata,
  output logic            [31:0]      prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   sample_tick,
  input  wire logic       [1:0][6:0]  agc_gain,
  output agsc_chan_s      [1:0]       chan_gain,
  output logic            [1:0]       chan_active,
  output logic                        irq
);

  localparam int NCH = 2;

  logic        [1:0][6:0]  amp_q;
  logic        [1:0][6:0]  vol_q;
  logic        [1:0]       prog_q;
  logic        [1:0]       step_q;
  logic        [7:0]       trim_q;
  logic        [8:0]       ctrl_q;
  logic        [3:0]       irq_stat_q;
  logic        [3:0]       irq_mask_q;
  logic        [31:0]      prdata_q;
  logic                    pslverr_q;
  logic                    half_q;
  logic        [1:0][7:0]  pga_app_q;
  logic        [1:0][7:0]  vol_app_q;
  logic        [1:0][7:0]  pga_tgt;
  logic        [1:0][7:0]  vol_tgt;
  logic        [1:0]       amp_hit;
  logic        [1:0]       vol_hit;
  logic        [1:0]       amp_hit_q;
  logic        [1:0]       vol_hit_q;
  logic        [1:0]       active_q;
  logic        [1:0][2:0]  trim_ch;
  logic        [3:0]       irq_evt;
  agsc_chan_s  [1:0]       chan_q;
  agsc_rate_e              rate;
  logic        [7:0]       idx;
  logic                    setup;
  logic                    wr;
  logic                    mapped;

  function automatic agsc_rate_e rate_of(input logic [1:0] f);
    unique case (f)
      2'h0:    rate_of = AGSC_RATE_FAST;
      2'h1:    rate_of = AGSC_RATE_SLOW;
      default: rate_of = AGSC_RATE_OFF;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [7:0] i);
    unique case (i)
      `AGSC_IDX_REACHED, `AGSC_IDX_AMP_L, `AGSC_IDX_AMP_R,
      `AGSC_IDX_SOFTSTEP, `AGSC_IDX_TRIM, `AGSC_IDX_VOL_L,
      `AGSC_IDX_VOL_R, `AGSC_IDX_CTRL, `AGSC_IDX_IRQ_STAT,
      `AGSC_IDX_IRQ_MASK, `AGSC_IDX_PWR_STAT: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // out-of-range volume codes saturate at the table ends
  function automatic logic [7:0] vol_clamp(input logic [6:0] c);
    logic signed [7:0] s;
    s = {c[6], c};
    if (s < $signed(`AGSC_VOL_MIN))
      vol_clamp = `AGSC_VOL_MIN;
    else if (s > $signed(`AGSC_VOL_MAX))
      vol_clamp = `AGSC_VOL_MAX;
    else
      vol_clamp = s;
  endfunction

  // reserved trim codes act as 0 dB
  function automatic logic [2:0] trim_ok(input logic [2:0] c);
    trim_ok = (c > `AGSC_TRIM_MAX) ? 3'h0 : c;
  endfunction

  // move cur toward tgt by at most n
  function automatic logic [7:0] step_to(input logic [7:0] cur,
                                         input logic [7:0] tgt,
                                         input logic [7:0] n);
    logic signed [8:0] d;
    d = $signed({tgt[7], tgt}) - $signed({cur[7], cur});
    if (d > $signed({1'b0, n}))
      step_to = 8'(cur + n);
    else if (d < -$signed({1'b0, n}))
      step_to = 8'(cur - n);
    else
      step_to = tgt;
  endfunction

  // apb slave, zero wait states

  assign idx     = paddr[9:2];
  assign setup   = psel && !penable;
  assign wr      = psel && penable && pwrite && mapped;
  assign mapped  = is_mapped(idx) && (paddr[1:0] == 2'h0);
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q && psel && penable;

  // read data captured in setup so it comes from a flip-flop
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= !mapped;
      prdata_q  <= 32'h0000_0000;
      if (!pwrite) begin
        unique case (idx)
          `AGSC_IDX_REACHED: begin
            prdata_q[`AGSC_BIT_REACH_L] <= amp_hit[0] && vol_hit[0];
            prdata_q[`AGSC_BIT_AMP_L]   <= amp_hit[0];
            prdata_q[`AGSC_BIT_VOL_L]   <= vol_hit[0];
            prdata_q[`AGSC_BIT_REACH_R] <= amp_hit[1] && vol_hit[1];
            prdata_q[`AGSC_BIT_AMP_R]   <= amp_hit[1];
            prdata_q[`AGSC_BIT_VOL_R]   <= vol_hit[1];
          end
          `AGSC_IDX_AMP_L:    prdata_q[6:0] <= amp_q[0];
          `AGSC_IDX_AMP_R:    prdata_q[6:0] <= amp_q[1];
          `AGSC_IDX_SOFTSTEP: prdata_q[1:0] <= step_q;
          `AGSC_IDX_TRIM:     prdata_q[7:0] <= trim_q;
          `AGSC_IDX_VOL_L:    prdata_q[6:0] <= vol_q[0];
          `AGSC_IDX_VOL_R:    prdata_q[6:0] <= vol_q[1];
          `AGSC_IDX_CTRL:     prdata_q[8:0] <= ctrl_q;
          `AGSC_IDX_IRQ_STAT: prdata_q[3:0] <= irq_stat_q;
          `AGSC_IDX_IRQ_MASK: prdata_q[3:0] <= irq_mask_q;
          `AGSC_IDX_PWR_STAT: prdata_q[1:0] <= active_q;
          default:            prdata_q      <= 32'h0000_0000;
        endcase
      end
    end
  end

  // software-written registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      amp_q      <= {NCH{`AGSC_RST_AMP}};
      vol_q      <= {NCH{`AGSC_RST_VOL}};
      step_q     <= `AGSC_RST_STEP;
      trim_q     <= `AGSC_RST_TRIM;
      ctrl_q     <= `AGSC_RST_CTRL;
      irq_mask_q <= 4'h0;
    end else if (wr) begin
      unique case (idx)
        `AGSC_IDX_AMP_L:    amp_q[0]   <= pwdata[6:0];
        `AGSC_IDX_AMP_R:    amp_q[1]   <= pwdata[6:0];
        `AGSC_IDX_SOFTSTEP: step_q     <= pwdata[1:0];
        `AGSC_IDX_TRIM:     trim_q     <= pwdata[7:0];
        `AGSC_IDX_VOL_L:    vol_q[0]   <= pwdata[6:0];
        `AGSC_IDX_VOL_R:    vol_q[1]   <= pwdata[6:0];
        `AGSC_IDX_CTRL:     ctrl_q     <= pwdata[8:0];
        `AGSC_IDX_IRQ_MASK: irq_mask_q <= pwdata[3:0];
        default:            ;
      endcase
    end
  end

  // outside agc mode, amp stays muted until its own register is first written
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prog_q <= 2'h0;
    end else if (wr) begin
      if (idx == `AGSC_IDX_AMP_L)
        prog_q[0] <= 1'b1;
      if (idx == `AGSC_IDX_AMP_R)
        prog_q[1] <= 1'b1;
    end
  end

  // sticky events, set beats the write-one clear
  assign irq_evt = {vol_hit[1] && !vol_hit_q[1], vol_hit[0] && !vol_hit_q[0],
                    amp_hit[1] && !amp_hit_q[1], amp_hit[0] && !amp_hit_q[0]};

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_stat_q <= 4'h0;
    end else begin
      if (wr && idx == `AGSC_IDX_IRQ_STAT)
        irq_stat_q <= (irq_stat_q & ~pwdata[3:0]) | irq_evt;
      else
        irq_stat_q <= irq_stat_q | irq_evt;
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // slow rate steps the amp on every second sample only
  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      half_q <= 1'b0;
    else if (sample_tick)
      half_q <= !half_q;
  end

  assign rate    = rate_of(step_q);
  assign trim_ch = {trim_ok(trim_q[`AGSC_TRIM_R +: 3]),
                    trim_ok(trim_q[`AGSC_TRIM_L +: 3])};

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic       on;
    logic       diff;
    logic [1:0] imp;
    logic [7:0] pga_n;
    logic [7:0] vol_n;
    logic       pga_go;

    assign on   = ctrl_q[`AGSC_CTRL_ON + c];
    assign diff = ctrl_q[`AGSC_CTRL_DIFF + c];
    assign imp  = (c == 0) ? ctrl_q[`AGSC_CTRL_IMP_L +: 2]
                           : ctrl_q[`AGSC_CTRL_IMP_R +: 2];

    // powered-down channel heads for the floor
    always_comb begin
      if (!on)
        pga_tgt[c] = `AGSC_PGA_MUTE;
      else if (ctrl_q[`AGSC_CTRL_AGC])
        pga_tgt[c] = {1'b0, agc_gain[c]};
      else if (prog_q[c])
        pga_tgt[c] = {1'b0, amp_q[c]};
      else
        pga_tgt[c] = `AGSC_PGA_MUTE;
      vol_tgt[c] = on ? vol_clamp(vol_q[c]) : `AGSC_VOL_MIN;
    end

    assign amp_hit[c] = (pga_app_q[c] == pga_tgt[c]);
    assign vol_hit[c] = (vol_app_q[c] == vol_tgt[c]);
    assign pga_go     = sample_tick && (rate == AGSC_RATE_FAST || half_q);

    always_comb begin
      pga_n = pga_app_q[c];
      vol_n = vol_app_q[c];
      unique case (rate)
        AGSC_RATE_OFF: begin
          pga_n = pga_tgt[c];
          vol_n = vol_tgt[c];
        end
        AGSC_RATE_SLOW: begin
          if (pga_go)
            pga_n = step_to(pga_app_q[c], pga_tgt[c], 8'h01);
          if (sample_tick)
            vol_n = step_to(vol_app_q[c], vol_tgt[c], 8'h02);
        end
        AGSC_RATE_FAST: begin
          if (pga_go)
            pga_n = step_to(pga_app_q[c], pga_tgt[c], 8'h01);
          if (sample_tick)
            vol_n = step_to(vol_app_q[c], vol_tgt[c], 8'h01);
        end
      endcase
    end

    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        pga_app_q[c] <= `AGSC_PGA_MUTE;
        vol_app_q[c] <= {1'b0, `AGSC_RST_VOL};
        amp_hit_q[c] <= 1'b1;
        vol_hit_q[c] <= 1'b1;
      end else begin
        pga_app_q[c] <= pga_n;
        vol_app_q[c] <= vol_n;
        amp_hit_q[c] <= amp_hit[c];
        vol_hit_q[c] <= vol_hit[c];
      end
    end

    // shut off only once both gains sit at the floor
    always_ff @(posedge clk_sys) begin
      if (sys_rst)
        active_q[c] <= 1'b0;
      else if (on)
        active_q[c] <= 1'b1;
      else if (pga_app_q[c] == `AGSC_PGA_MUTE &&
               vol_app_q[c] == `AGSC_VOL_MIN)
        active_q[c] <= 1'b0;
    end

    // effective gain; unity filter gain adds no term
    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        chan_q[c] <= '0;
        chan_q[c].pga_mute <= 1'b1;
      end else begin
        chan_q[c].pga_mute <= (pga_app_q[c] == `AGSC_PGA_MUTE);
        chan_q[c].pga_hdb <= (pga_app_q[c] == `AGSC_PGA_MUTE) ? 9'h000 :
          9'({1'b0, pga_app_q[c]} + (diff ? `AGSC_DIFF_BOOST : 9'h000)
             - 9'(imp * `AGSC_IMP_STEP));
        chan_q[c].vol_hdb    <= vol_app_q[c][6:0];
        chan_q[c].trim_tenth <= trim_ch[c];
        chan_q[c].total_tenth <= 11'(
          ($signed({{2{chan_q[c].pga_hdb[8]}}, chan_q[c].pga_hdb}) +
           $signed({{4{chan_q[c].vol_hdb[6]}}, chan_q[c].vol_hdb}))
          * $signed(`AGSC_TENTHS_PER_HDB)
          - $signed({8'h00, chan_q[c].trim_tenth}));
      end
    end

    sequence s_fall_floor;
      pga_app_q[c] == `AGSC_PGA_MUTE && vol_app_q[c] == `AGSC_VOL_MIN;
    endsequence

    a_reset_mute: assert property (@(posedge clk_sys)
      sys_rst |=> pga_app_q[c] == `AGSC_PGA_MUTE && !active_q[c])
      else $error("amp gain not muted after reset");

    a_unprog_mute: assert property (@(posedge clk_sys)
      disable iff (sys_rst)
      !prog_q[c] && !ctrl_q[`AGSC_CTRL_AGC] |-> pga_tgt[c] == `AGSC_PGA_MUTE)
      else $error("amp target left mute before programming");

    a_agc_source: assert property (@(posedge clk_sys)
      disable iff (sys_rst)
      on && ctrl_q[`AGSC_CTRL_AGC] |-> pga_tgt[c] == {1'b0, agc_gain[c]})
      else $error("agc gain not selected in agc mode");

    a_hold_between: assert property (@(posedge clk_sys)
      disable iff (sys_rst)
      !sample_tick && rate != AGSC_RATE_OFF ##1 rate != AGSC_RATE_OFF
      |-> $stable(pga_app_q[c]) && $stable(vol_app_q[c]))
      else $error("gain moved without a sample");

    a_fast_step: assert property (@(posedge clk_sys)
      disable iff (sys_rst)
      sample_tick && rate == AGSC_RATE_FAST &&
      $signed(pga_app_q[c]) < $signed(pga_tgt[c])
      |=> pga_app_q[c] == 8'($past(pga_app_q[c]) + 8'h01))
      else $error("amp did not rise one step");

    a_vol_double: assert property (@(posedge clk_sys)
      disable iff (sys_rst)
      sample_tick && rate == AGSC_RATE_SLOW &&
      $signed(vol_tgt[c]) > $signed(8'(vol_app_q[c] + 8'h02))
      |=> vol_app_q[c] == 8'($past(vol_app_q[c]) + 8'h02))
      else $error("volume did not take two steps");

    a_off_jump: assert property (@(posedge clk_sys)
      disable iff (sys_rst)
      rate == AGSC_RATE_OFF ##1 rate == AGSC_RATE_OFF &&
      $stable(pga_tgt[c]) && $stable(vol_tgt[c])
      |-> amp_hit[c] && vol_hit[c])
      else $error("disabled stepping did not jump");

    a_floor_off: assert property (@(posedge clk_sys)
      disable iff (sys_rst)
      $fell(active_q[c]) |-> !$past(on) && $past(pga_app_q[c]) ==
      `AGSC_PGA_MUTE && $past(vol_app_q[c]) == `AGSC_VOL_MIN)
      else $error("channel shut off above the floor");
    a_vol_range: assert property (@(posedge clk_sys)
      disable iff (sys_rst)
      $signed(vol_app_q[c]) >= $signed(`AGSC_VOL_MIN) &&
      $signed(vol_app_q[c]) <= $signed(`AGSC_VOL_MAX))
      else $error("applied volume out of range");
    a_reach_event: assert property (@(posedge clk_sys)
      disable iff (sys_rst)
      amp_hit[c] && !amp_hit_q[c] |=> irq_stat_q[c])
      else $error("reached event not latched");

    a_floor_seen: assert property (@(posedge clk_sys)
      disable iff (sys_rst)
      (!on and s_fall_floor) |=> !active_q[c])
      else $error("channel stays active at the floor");
  end

  assign chan_gain   = chan_q;
  assign chan_active = active_q;

endmodule
